// ### acjo_top.v
// active configuration controller jtag override: release, clock source, flash start address
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "acjo_regs.vh"

module acjo_top #(
    parameter IR_W = `ACJO_IR_W,
    parameter FA_W = `ACJO_FA_W
) (
    input  wire              clk,
    input  wire              rst_b,
    input  wire              tck,
    input  wire              tms,
    input  wire              tdi,
    output reg               tdo_q,
    output reg               tdo_oe_q,
    input  wire [1:0]        scheme_sel,
    input  wire              reconfig_request_pin_n,
    input  wire              user_supplied_clock_pin,
    input  wire              cfg_user_mode,
    input  wire              cfg_jtag_loaded,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    output reg               ctrl_idle_q,
    output reg               ctrl_user_q,
    output reg               reconfig_start_q,
    output reg               clk_src_ext_q,
    output reg               osc_en_q,
    output reg  [FA_W+1:0]   boot_addr_q,
    output reg               boot_factory_only_q
);

    // tap states
    localparam TLR = 4'h0;
    localparam RTI = 4'h1;
    localparam SDR = 4'h2;
    localparam CDR = 4'h3;
    localparam HDR = 4'h4;
    localparam X1D = 4'h5;
    localparam PDR = 4'h6;
    localparam X2D = 4'h7;
    localparam UDR = 4'h8;
    localparam SIR = 4'h9;
    localparam CIR = 4'hA;
    localparam HIR = 4'hB;
    localparam X1I = 4'hC;
    localparam PIR = 4'hD;
    localparam X2I = 4'hE;
    localparam UIR = 4'hF;
    // active controller states
    localparam CS_RUN  = 2'h0;
    localparam CS_IDLE = 2'h1;
    localparam CS_USER = 2'h2;

    // standard tap walk on one tms sample
    function [3:0] tap_next;
        input [3:0] st;
        input       m;
        begin
            case (st)
                TLR: tap_next = m ? TLR : RTI;
                RTI: tap_next = m ? SDR : RTI;
                SDR: tap_next = m ? SIR : CDR;
                CDR: tap_next = m ? X1D : HDR;
                HDR: tap_next = m ? X1D : HDR;
                X1D: tap_next = m ? UDR : PDR;
                PDR: tap_next = m ? X2D : PDR;
                X2D: tap_next = m ? UDR : HDR;
                UDR: tap_next = m ? SDR : RTI;
                SIR: tap_next = m ? TLR : CIR;
                CIR: tap_next = m ? X1I : HIR;
                HIR: tap_next = m ? X1I : HIR;
                X1I: tap_next = m ? UIR : PIR;
                PIR: tap_next = m ? X2I : PIR;
                X2I: tap_next = m ? UIR : HIR;
                default: tap_next = m ? SDR : RTI;
            endcase
        end
    endfunction

    // pin synchronisers; only the second stage is looked at
    reg  [1:0]       tck_s_q;
    reg  [1:0]       tms_s_q;
    reg  [1:0]       tdi_s_q;
    reg  [1:0]       ucl_s_q;
    reg  [1:0]       req_s_q;
    reg  [1:0]       sch0_s_q;
    reg  [1:0]       sch1_s_q;
    reg              tck_d1_q;
    reg              ucl_d1_q;
    reg              req_d1_q;
    reg              um_d1_q;

    reg  [3:0]       tap_q;
    reg  [IR_W-1:0]  ir_sh_q;
    reg  [IR_W-1:0]  ir_q;
    reg              byp_q;
    reg  [FA_W-1:0]  fa_sh_q;
    reg  [FA_W-1:0]  fa_up_q;
    reg  [1:0]       cst_q;
    reg              latch_q;
    reg              revert_q;
    reg  [3:0]       rev_cnt_q;
    reg  [1:0]       ctrl_q;

    wire       tck_s    = tck_s_q[1];
    wire       tck_rise = tck_s & ~tck_d1_q;
    wire       tck_fall = ~tck_s & tck_d1_q;
    wire       tms_s    = tms_s_q[1];
    wire       tdi_s    = tdi_s_q[1];
    wire       ucl_rise = ucl_s_q[1] & ~ucl_d1_q;
    wire       req_fall = ~req_s_q[1] & req_d1_q;
    wire [1:0] sch      = {sch1_s_q[1], sch0_s_q[1]};
    wire       um_rise  = cfg_user_mode & ~um_d1_q;
    wire       ru_en    = ctrl_q[`ACJO_CTRL_RU_BIT];
    wire       ed_en    = ctrl_q[`ACJO_CTRL_ED_BIT];

    wire       act_sch  = (sch == `ACJO_SCH_SACT) | (sch == `ACJO_SCH_PACT);
    wire [3:0] tap_n    = tap_next(tap_q, tms_s);
    // an instruction executes when update-ir latches it
    wire       exec     = tck_rise & (tap_q == UIR);
    wire       x_rel    = exec & (ir_sh_q == `ACJO_I_RELEASE);
    wire       x_rea    = exec & (ir_sh_q == `ACJO_I_REATTACH);
    wire       x_pul    = exec & (ir_sh_q == `ACJO_I_PULSE);
    wire       x_esel   = exec & (ir_sh_q == `ACJO_I_EXTSEL);
    wire       x_erel   = exec & (ir_sh_q == `ACJO_I_EXTREL);
    wire       tap_rst  = tck_rise & (tap_n == TLR) & (tap_q != TLR);
    wire       fa_ir    = (ir_q == `ACJO_I_FLASHADDR);
    wire       pin_mask = (ir_q == `ACJO_I_REATTACH);
    // pin request is honoured unless the reattach instruction holds the pin off
    wire       pin_req  = req_fall & ~pin_mask;
    // reattach restarts configuration in every scheme
    wire       restart  = x_rea | x_pul | pin_req;

    // two flip-flop synchronisers and delayed copies for edge detection
    always @(posedge clk) begin
        if (!rst_b) begin
            tck_s_q  <= 2'h0;
            tms_s_q  <= 2'h3;
            tdi_s_q  <= 2'h3;
            ucl_s_q  <= 2'h0;
            req_s_q  <= 2'h3;
            sch0_s_q <= 2'h0;
            sch1_s_q <= 2'h0;
            tck_d1_q <= 1'b0;
            ucl_d1_q <= 1'b0;
            req_d1_q <= 1'b1;
            um_d1_q  <= 1'b0;
        end else begin
            tck_s_q  <= {tck_s_q[0], tck};
            tms_s_q  <= {tms_s_q[0], tms};
            tdi_s_q  <= {tdi_s_q[0], tdi};
            ucl_s_q  <= {ucl_s_q[0], user_supplied_clock_pin};
            req_s_q  <= {req_s_q[0], reconfig_request_pin_n};
            sch0_s_q <= {sch0_s_q[0], scheme_sel[0]};
            sch1_s_q <= {sch1_s_q[0], scheme_sel[1]};
            tck_d1_q <= tck_s;
            ucl_d1_q <= ucl_s_q[1];
            req_d1_q <= req_s_q[1];
            um_d1_q  <= cfg_user_mode;
        end
    end

    // tap controller and instruction register, stepped on sampled tck rise
    always @(posedge clk) begin
        if (!rst_b) begin
            tap_q   <= TLR;
            ir_sh_q <= `ACJO_I_BYPASS;
            ir_q    <= `ACJO_I_BYPASS;
        end else if (tck_rise) begin
            tap_q <= tap_n;
            if (tap_q == TLR)
                ir_q <= `ACJO_I_BYPASS;
            else if (tap_q == CIR)
                ir_sh_q <= `ACJO_IR_CAPTURE;
            else if (tap_q == HIR)
                ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
            else if (tap_q == UIR)
                ir_q <= ir_sh_q;
        end
    end

    // data registers: bypass bit and flash start address path
    // the update register is reset only by power-on, so it outlives reconfiguration
    always @(posedge clk) begin
        if (!rst_b) begin
            byp_q   <= 1'b0;
            fa_sh_q <= `ACJO_FA_RST;
            fa_up_q <= `ACJO_FA_RST;
        end else if (tck_rise) begin
            if (tap_q == CDR) begin
                byp_q <= 1'b0;
                if (fa_ir)
                    fa_sh_q <= fa_up_q;
            end else if (tap_q == HDR) begin
                byp_q <= tdi_s;
                if (fa_ir)
                    fa_sh_q <= {tdi_s, fa_sh_q[FA_W-1:1]};
            end else if ((tap_q == UDR) && fa_ir) begin
                fa_up_q <= fa_sh_q;
            end
        end
    end

    // tdo changes on the sampled falling edge of tck, driven only while shifting
    always @(posedge clk) begin
        if (!rst_b) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_q <= (tap_q == HIR) | (tap_q == HDR);
            if (tap_q == HIR)
                tdo_q <= ir_sh_q[0];
            else if (fa_ir)
                tdo_q <= fa_sh_q[0];
            else
                tdo_q <= byp_q;
        end
    end

    // active controller state: running, released (idle) or in user mode
    always @(posedge clk) begin
        if (!rst_b) begin
            cst_q <= CS_RUN;
        end else if (x_rel) begin
            if (act_sch)
                cst_q <= CS_IDLE;
            // passive scheme: release has no effect
        end else if (x_rea) begin
            if (act_sch)
                cst_q <= CS_RUN;
        end else if (tap_rst && (cst_q == CS_IDLE) && (sch == `ACJO_SCH_SACT)) begin
            cst_q <= CS_RUN;
        end else if (um_rise) begin
            // a released controller goes to user mode only when cfg_jtag_loaded is set
            if ((cst_q == CS_IDLE) && cfg_jtag_loaded)
                cst_q <= CS_USER;
            else if (cst_q == CS_RUN)
                cst_q <= CS_USER;
        end else if (restart && (cst_q == CS_USER)) begin
            // pin or pulse never leaves the idle state, only user mode
            cst_q <= CS_RUN;
        end
    end

    // oscillator enable: on by default, off in user mode unless kept alive
    always @(posedge clk) begin
        if (!rst_b)
            osc_en_q <= 1'b1;
        else if (restart || ru_en || ed_en)
            osc_en_q <= 1'b1;
        else if (um_rise)
            osc_en_q <= 1'b0;
    end

    // external clock select latch and the delayed revert of the source
    // revert waits for ten user clock edges; a stopped user clock leaves it selected
    always @(posedge clk) begin
        if (!rst_b) begin
            latch_q       <= 1'b0;
            revert_q      <= 1'b0;
            rev_cnt_q     <= 4'h0;
            clk_src_ext_q <= 1'b0;
        end else begin
            if (x_esel) begin
                latch_q  <= 1'b1;
                revert_q <= 1'b0;
            end else if (x_erel) begin
                latch_q   <= 1'b0;
                revert_q  <= clk_src_ext_q;
                rev_cnt_q <= 4'h0;
            end else if (revert_q && ucl_rise) begin
                rev_cnt_q <= rev_cnt_q + 4'h1;
                if (rev_cnt_q + 4'h1 == `ACJO_REVERT_EDGES) begin
                    revert_q      <= 1'b0;
                    clk_src_ext_q <= 1'b0;
                end
            end
            // the switch-over needs the oscillator running; other instructions
            // and the tap reset leave the latch alone
            if (latch_q && osc_en_q && !x_erel)
                clk_src_ext_q <= 1'b1;
        end
    end

    // controller outputs and restart pulse
    always @(posedge clk) begin
        if (!rst_b) begin
            ctrl_idle_q      <= 1'b0;
            ctrl_user_q      <= 1'b0;
            reconfig_start_q <= 1'b0;
        end else begin
            ctrl_idle_q      <= (cst_q == CS_IDLE);
            ctrl_user_q      <= (cst_q == CS_USER);
            // released active controller is not restarted by pin or pulse
            reconfig_start_q <= x_rea | ((x_pul | pin_req) & (cst_q != CS_IDLE));
        end
    end

    // boot address to the parallel flash controller
    always @(posedge clk) begin
        if (!rst_b) begin
            boot_addr_q         <= {(FA_W+2){1'b0}};
            boot_factory_only_q <= 1'b0;
        end else begin
            boot_addr_q         <= {fa_up_q, 2'b00};
            boot_factory_only_q <= ru_en;
        end
    end

    // apb slave: no wait state, pready raised for the access cycle
    always @(posedge clk) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            ctrl_q  <= `ACJO_CTRL_RST;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                prdata  <= 32'h00000000;
                pslverr <= 1'b0;
                if (paddr == `ACJO_CTRL_OFS) begin
                    prdata[1:0] <= ctrl_q;
                end else if (paddr == `ACJO_STAT_OFS) begin
                    if (!pwrite)
                        prdata <= {{(24-IR_W){1'b0}}, ir_q, 1'b0, osc_en_q,
                                   clk_src_ext_q, latch_q, cst_q, sch};
                    else
                        pslverr <= 1'b1;
                end else if (paddr == `ACJO_BOOT_OFS) begin
                    if (!pwrite)
                        prdata <= {{(30-FA_W){1'b0}}, boot_addr_q};
                    else
                        pslverr <= 1'b1;
                end else begin
                    pslverr <= 1'b1;
                end
            end
            // writes take effect on the access edge only
            if (psel && penable && pready && pwrite && (paddr == `ACJO_CTRL_OFS))
                ctrl_q <= pwdata[1:0];
        end
    end

endmodule // acjo_top

// ### acjo_regs.vh
// constants for the active configuration jtag override block
`ifndef ACJO_REGS_VH
`define ACJO_REGS_VH

// apb register byte offsets
`define ACJO_CTRL_OFS      8'h00
`define ACJO_STAT_OFS      8'h04
`define ACJO_BOOT_OFS      8'h08
// control register fields and reset value
`define ACJO_CTRL_RU_BIT   0
`define ACJO_CTRL_ED_BIT   1
`define ACJO_CTRL_RST      2'h0
// status register field positions
`define ACJO_ST_SCH_LSB    0
`define ACJO_ST_CST_LSB    2
`define ACJO_ST_LATCH_BIT  4
`define ACJO_ST_SRC_BIT    5
`define ACJO_ST_OSC_BIT    6
`define ACJO_ST_IR_LSB     8

// configuration schemes on the scheme select pins
`define ACJO_SCH_SPAS      2'h0
`define ACJO_SCH_PPAS      2'h1
`define ACJO_SCH_SACT      2'h2
`define ACJO_SCH_PACT      2'h3

// instruction codes (values are arbitrary)
`define ACJO_IR_W          10
`define ACJO_I_BYPASS      10'h3FF
`define ACJO_I_RELEASE     10'h002
`define ACJO_I_REATTACH    10'h00B
`define ACJO_I_PULSE       10'h001
`define ACJO_I_EXTSEL      10'h00E
`define ACJO_I_EXTREL      10'h00F
`define ACJO_I_FLASHADDR   10'h027
`define ACJO_IR_CAPTURE    10'h001

// flash start address scan path and reset values
`define ACJO_FA_W          22
`define ACJO_FA_RST        22'h000000

// user clock edges needed before the source reverts
`define ACJO_REVERT_EDGES  4'hA
`endif

// ### acjo_assertions.sv
// checker bound to the override block top, watching its ports only
`timescale 1ns/10ps
module acjo_checker #(
    parameter FA_W = 22
) (
    input wire            clk,
    input wire            rst_b,
    input wire [1:0]      scheme_sel,
    input wire            cfg_user_mode,
    input wire            ctrl_idle_q,
    input wire            ctrl_user_q,
    input wire            reconfig_start_q,
    input wire            clk_src_ext_q,
    input wire            osc_en_q,
    input wire [FA_W+1:0] boot_addr_q
);
    default clocking config_data_clock @(posedge clk); endclocking
    default disable iff (!rst_b);

    // flash controller never sees the two inaccessible low address bits
    a_boot_low_zero: assert property (
        boot_addr_q[1:0] == 2'h0) else $error("boot address low bits not zero");
    // switching to the user clock needs a running oscillator
    a_src_needs_osc: assert property (
        $rose(clk_src_ext_q) |-> $past(osc_en_q)) else $error("source switched with osc off");
    a_start_pulse: assert property (
        reconfig_start_q |=> !reconfig_start_q) else $error("start is not a pulse");
    a_start_runs: assert property (
        reconfig_start_q |=> !ctrl_idle_q) else $error("restart left controller idle");
    // power-on state: oscillator source, address cleared
    a_reset_values: assert property (
        $rose(rst_b) |-> osc_en_q && !clk_src_ext_q && boot_addr_q == 0)
        else $error("bad state after power-on");
    a_state_excl: assert property (
        !(ctrl_idle_q && ctrl_user_q)) else $error("idle and user together");
    // scheme pins are held steady in the bench, so sync lag does not matter
    a_idle_active: assert property (
        $rose(ctrl_idle_q) |-> scheme_sel[1]) else $error("release took in passive scheme");
    a_user_cause: assert property (
        $rose(ctrl_user_q) |-> cfg_user_mode) else $error("user state without user mode");
    a_boot_survive: assert property (
        reconfig_start_q |=> $stable(boot_addr_q)) else $error("address lost on restart");

    c_release: cover property ($rose(ctrl_idle_q));
    c_revert: cover property ($fell(clk_src_ext_q));
    c_start: cover property (reconfig_start_q);
endmodule // acjo_checker

bind acjo_top acjo_checker #(.FA_W(FA_W)) chk_u (
    .clk(clk), .rst_b(rst_b), .scheme_sel(scheme_sel), .cfg_user_mode(cfg_user_mode),
    .ctrl_idle_q(ctrl_idle_q), .ctrl_user_q(ctrl_user_q),
    .reconfig_start_q(reconfig_start_q), .clk_src_ext_q(clk_src_ext_q),
    .osc_en_q(osc_en_q), .boot_addr_q(boot_addr_q));

// ### acjo_jtag_host.sv
// jtag test host and user clock source facing the override block
`timescale 1ns/10ps
module acjo_jtag_host (
    input  wire clk,
    output reg  tck,
    output reg  tms,
    output reg  tdi,
    input  wire tdo,
    output reg  uclk
);
    reg uclk_run;

    // user clock at 2.5 MHz, far below the 40 MHz ceiling; parks low when stopped
    initial begin
        tck = 0;
        tms = 1;
        tdi = 0;
        uclk = 0;
        uclk_run = 0;
        #13;
        forever begin
            #200;
            if (uclk_run || uclk) uclk = ~uclk;
        end
    end

    // one tck period of 8 clk; tdo taken 6 clk after the fall, where it has settled
    task tick(input m, input d, output o);
        begin
            @(posedge clk) tck <= 0;
            tms <= m;
            tdi <= d;
            repeat (4) @(posedge clk);
            tck <= 1;
            repeat (2) @(posedge clk);
            o = tdo;
            @(posedge clk);
        end
    endtask

    // ir or dr scan from run-test-idle back to run-test-idle, lsb first
    task scan(input ir, input [21:0] d, input integer n, output [21:0] q);
        integer i;
        reg     o;
        begin
            q = 22'h000000;
            tick(1, 0, o);
            if (ir) tick(1, 0, o);
            tick(0, 0, o);
            tick(0, 0, o);
            for (i = 0; i < n; i = i + 1) begin
                tick(i == n - 1, d[i], o);
                q[i] = o;
            end
            tick(1, 0, o);
            tick(0, 0, o);
        end
    endtask

    task tap_reset;
        reg o;
        begin
            repeat (5) tick(1, 0, o);
            tick(0, 0, o);
        end
    endtask
endmodule // acjo_jtag_host

// ### active_config_jtag_override_bench.sv
// self-checking bench for the active configuration jtag override block
`timescale 1ns/10ps
`include "acjo_regs.vh"
module active_config_jtag_override_bench;
    reg         clk, rst_b, psel, penable, pwrite, pin_n, umode, jloaded;
    reg  [1:0]  scheme;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready, pslverr, tck, tms, tdi, tdo, uclk, idle, user, start, src, osc, fact;
    wire [23:0] boot;
    integer     miscompares, checked, starts;

    always #25 clk = ~clk;
    // count restart pulses; they stand one clk only
    always @(posedge clk) if (start === 1'b1) starts = starts + 1;

    acjo_top dut_u (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo_q(tdo), .tdo_oe_q(), .scheme_sel(scheme), .reconfig_request_pin_n(pin_n),
        .user_supplied_clock_pin(uclk), .cfg_user_mode(umode), .cfg_jtag_loaded(jloaded),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl_idle_q(idle),
        .ctrl_user_q(user), .reconfig_start_q(start), .clk_src_ext_q(src),
        .osc_en_q(osc), .boot_addr_q(boot), .boot_factory_only_q(fact));
    acjo_jtag_host host_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .uclk(uclk));

    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask

    task chk(input [31:0] g, input [31:0] e, input string m);
        begin
            checked = checked + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
            end
        end
    endtask

    // apb transfer; waits for pready under a bound
    task apb(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
        integer n;
        begin
            @(posedge clk) psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk) penable <= 1;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 20);
            if (n >= 20) begin
                miscompares = miscompares + 1;
                give_verdict;
            end
            q = prdata;
            e = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask

    task ir(input [9:0] c);
        reg [21:0] q;
        begin
            host_u.scan(1, {12'h000, c}, 10, q);
            // outputs follow the update-ir edge of tck by up to four clk; let them settle
            repeat (4) @(posedge clk);
        end
    endtask

    task set_scheme(input [1:0] s);
        begin
            @(posedge clk) scheme <= s;
            repeat (4) @(posedge clk);
        end
    endtask

    // request pin low for 12 clk, above the 500 ns minimum
    task pin_pulse;
        begin
            @(posedge clk) pin_n <= 0;
            repeat (12) @(posedge clk);
            pin_n <= 1;
            repeat (12) @(posedge clk);
        end
    endtask

    task do_reset;
        begin
            @(posedge clk) rst_b <= 0;
            repeat (6) @(posedge clk);
            rst_b <= 1;
            repeat (4) @(posedge clk);
        end
    endtask

    task t_reset;
        reg [31:0] q;
        reg        e;
        begin
            chk(src, 0, "src");
            chk(osc, 1, "osc");
            chk(boot, 0, "boot");
            apb(0, `ACJO_CTRL_OFS, 0, q, e);
            chk(q, 0, "ctrl");
            apb(1, `ACJO_STAT_OFS, 32'hFFFFFFFF, q, e);
            chk(e, 1, "read-only");
            apb(0, `ACJO_STAT_OFS, 0, q, e);
            chk(q, {14'h0000, `ACJO_I_BYPASS, 8'h42}, "status");
            apb(0, 8'h40, 0, q, e);
            chk(e, 1, "unmapped");
            $display("t_reset done");
        end
    endtask

    // oscillator is running here, so the switch may happen
    task t_clock;
        begin
            ir(`ACJO_I_EXTSEL);
            chk(src, 1, "ext select");
            ir(`ACJO_I_BYPASS);
            host_u.tap_reset;
            chk(src, 1, "kept");
            pin_pulse;
            chk(src, 1, "pin kept");
            ir(`ACJO_I_EXTREL);
            repeat (40) @(posedge clk);
            chk(src, 1, "no edges");
            host_u.uclk_run = 1;
            repeat (96) @(posedge clk);
            host_u.uclk_run = 0;
            repeat (8) @(posedge clk);
            chk(src, 0, "revert");
            $display("t_clock done");
        end
    endtask

    task t_release;
        integer n;
        begin
            set_scheme(`ACJO_SCH_SPAS);
            ir(`ACJO_I_RELEASE);
            chk(idle, 0, "passive");
            set_scheme(`ACJO_SCH_SACT);
            ir(`ACJO_I_RELEASE);
            chk(idle, 1, "release");
            n = starts;
            host_u.tap_reset;
            chk(idle, 0, "tap reset");
            chk(starts, n, "no pulse");
            $display("t_release done");
        end
    endtask

    task t_parallel;
        integer n;
        begin
            set_scheme(`ACJO_SCH_PACT);
            ir(`ACJO_I_RELEASE);
            pin_pulse;
            chk(idle, 1, "pin");
            host_u.tap_reset;
            chk(idle, 1, "tap");
            n = starts;
            ir(`ACJO_I_REATTACH); // fail-safe use only
            chk(idle, 0, "reattach");
            chk(starts, n + 1, "restart");
            pin_pulse;
            chk(starts, n + 1, "pin ignored");
            $display("t_parallel done");
        end
    endtask

    task t_passive;
        integer n;
        integer s;
        begin
            for (s = 0; s < 2; s = s + 1) begin
                set_scheme(s[1:0]);
                n = starts;
                ir(`ACJO_I_REATTACH);
                chk(starts, n + 1, "reattach");
                ir(`ACJO_I_PULSE);
                chk(starts, n + 2, "pulse");
            end
            $display("t_passive done");
        end
    endtask

    task t_user;
        reg [31:0] q;
        reg        e;
        begin
            set_scheme(`ACJO_SCH_SACT);
            ir(`ACJO_I_RELEASE);
            @(posedge clk) jloaded <= 1;
            umode <= 1;
            repeat (4) @(posedge clk);
            chk(user, 1, "user");
            chk(osc, 0, "osc off");
            pin_pulse;
            chk(osc, 1, "osc on");
            apb(1, `ACJO_CTRL_OFS, 32'h00000001, q, e);
            apb(0, `ACJO_CTRL_OFS, 0, q, e);
            chk(q, 1, "ctrl");
            chk(fact, 1, "factory");
            @(posedge clk) umode <= 0;
            jloaded <= 0;
            $display("t_user done");
        end
    endtask

    task t_boot;
        reg [21:0] q;
        integer    n;
        begin
            set_scheme(`ACJO_SCH_PACT);
            ir(`ACJO_I_FLASHADDR);
            host_u.scan(0, 22'h2A5A5C, 22, q);
            chk(q, 0, "capture old");
            host_u.scan(0, 22'h15A5A3, 22, q);
            repeat (4) @(posedge clk);
            chk(q, 22'h2A5A5C, "shift out");
            chk(boot, {22'h15A5A3, 2'h0}, "boot");
            ir(`ACJO_I_BYPASS);
            host_u.scan(0, 22'h3FFFFF, 22, q);
            chk(boot, {22'h15A5A3, 2'h0}, "bypass");
            n = starts;
            ir(`ACJO_I_REATTACH);
            chk(starts, n + 1, "restart");
            chk(boot, {22'h15A5A3, 2'h0}, "kept");
            do_reset;
            chk(boot, 0, "power cycle");
            $display("t_boot done");
        end
    endtask

    initial begin
        clk = 0;
        rst_b = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pin_n = 1;
        umode = 0;
        jloaded = 0;
        scheme = `ACJO_SCH_SACT;
        miscompares = 0;
        checked = 0;
        starts = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1;
        repeat (4) @(posedge clk);
        t_reset;
        // the tap leaves reset in test-logic-reset; scans start from run-test-idle
        host_u.tap_reset;
        t_clock;
        t_release;
        t_parallel;
        t_passive;
        t_user;
        t_boot;
        give_verdict;
    end
endmodule // active_config_jtag_override_bench
